// ### src/mid_core.sv
// Instruction sequencer: four-phase cycle, read-modify-write, cycle costs, APB view
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "mid_map.svh"
module mid_core (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Program memory side
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    output logic fetch_take,
    output logic flow_change,
    // File register side
    output logic [6:0] fr_addr,
    output logic fr_rd,
    input wire logic [7:0] fr_rdata,
    output logic fr_wr,
    output logic [7:0] fr_wdata,
    // Indirect pointer stepping
    output logic indirect_pointer_step,
    output logic indirect_pointer_sel,
    output mid_pkg::mid_step_t ptr_step_style
);
    import mid_pkg::*;

    typedef struct packed {
        mid_q_t q;
        logic [13:0] ir;
        logic kill;
        logic stall;
        logic pflow;
        logic [7:0] w;
        logic [7:0] fdat;
        logic [1:0] last_cost;
        logic run;
        logic [1:0] ptr_prog;
        logic [15:0] retired;
        logic [6:0] fr_addr;
        logic fr_rd;
        logic fr_wr;
        logic [7:0] fr_wdata;
        logic fetch;
        logic flow;
        logic step;
        logic step_sel;
        mid_step_t step_style;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mid_core_st_t;

    localparam mid_core_st_t ST_RST = '{
        q: MID_Q1,
        ir: `MID_NOP,
        w: `MID_RST_W,
        run: `MID_RST_RUN,
        ptr_prog: `MID_RST_PTRSRC,
        step_style: MID_STEP_PREINC,
        default: '0
    };

    mid_core_st_t r_ff;
    mid_core_st_t nxt_r;

    // ------------------------------------------------------------
    // Decode and modify
    // ------------------------------------------------------------
    mid_cls_t cls;
    logic [6:0] dec_addr;
    logic [2:0] bit_no;
    logic dest_file;
    logic dest_w;
    logic uses_file;
    logic ind_use;
    logic ind_sel;
    logic ptr_step;
    mid_step_t step_style;
    logic flow_fix;
    mid_skip_t skip;
    logic [7:0] res;
    logic skip_hit;
    logic ex;
    logic ind_hit;
    logic take;
    logic apb_wr;

    mid_dec u_dec (
        .instr(r_ff.ir),
        .cls(cls),
        .file_addr(dec_addr),
        .bit_no(bit_no),
        .dest_file(dest_file),
        .dest_w(dest_w),
        .uses_file(uses_file),
        .ind_use(ind_use),
        .ind_sel(ind_sel),
        .ptr_step(ptr_step),
        .ptr_step_style(step_style),
        .flow_fix(flow_fix),
        .skip(skip)
    );

    mid_alu u_alu (
        .instr(r_ff.ir),
        .bit_no(bit_no),
        .skip(skip),
        .fval(r_ff.fdat),
        .wval(r_ff.w),
        .res(res),
        .skip_hit(skip_hit)
    );

    // Killed and stall cycles execute nothing
    assign ex = !r_ff.kill && !r_ff.stall;
    assign ind_hit = ex && ind_use && r_ff.ptr_prog[ind_sel];
    assign take = ex && (flow_fix || skip_hit);
    assign apb_wr = psel && penable && r_ff.pready && pwrite && !r_ff.pslverr && pstrb[0];

    // ------------------------------------------------------------
    // Sequencer and register slave
    // ------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        nxt_r.fr_rd = 1'b0;
        nxt_r.fr_wr = 1'b0;
        nxt_r.fetch = 1'b0;
        nxt_r.flow = 1'b0;
        nxt_r.step = 1'b0;
        nxt_r.pready = 1'b0;
        nxt_r.pslverr = 1'b0;
        if (r_ff.run) begin
            // Four clocks per instruction cycle
            case (r_ff.q)
                MID_Q1: begin
                    nxt_r.q = MID_Q2;
                    if (ex && uses_file) begin
                        // Read even when only a write follows
                        nxt_r.fr_rd = 1'b1;
                        nxt_r.fr_addr = dec_addr;
                    end
                end
                MID_Q2: begin
                    nxt_r.q = MID_Q3;
                    nxt_r.fdat = fr_rdata;
                end
                MID_Q3: begin
                    nxt_r.q = MID_Q4;
                    if (ex) begin
                        if (dest_file && uses_file) begin
                            nxt_r.fr_wr = 1'b1;
                            nxt_r.fr_wdata = res;
                        end else if (dest_w) begin
                            nxt_r.w = res;
                        end
                        if (ptr_step) begin
                            nxt_r.step = 1'b1;
                            nxt_r.step_sel = ind_sel;
                            nxt_r.step_style = step_style;
                        end
                    end
                end
                MID_Q4: begin
                    nxt_r.q = MID_Q1;
                    if (ind_hit) begin
                        // Hold the fetch for one added cycle
                        nxt_r.stall = 1'b1;
                        nxt_r.pflow = take;
                    end else begin
                        nxt_r.fetch = 1'b1;
                        nxt_r.stall = 1'b0;
                        if (take || (r_ff.stall && r_ff.pflow)) begin
                            // Word fetched meanwhile runs as a no-operation
                            nxt_r.ir = `MID_NOP;
                            nxt_r.kill = 1'b1;
                            nxt_r.flow = 1'b1;
                        end else begin
                            // Plain instructions free the next cycle
                            nxt_r.ir = instr_valid ? instr_word : `MID_NOP;
                            nxt_r.kill = 1'b0;
                        end
                    end
                    if (ex) begin
                        nxt_r.retired = r_ff.retired + 16'h0001;
                        nxt_r.last_cost = `MID_COST_ONE + {1'b0, ind_hit} + {1'b0, take};
                    end
                end
                default: nxt_r.q = MID_Q1;
            endcase
        end
        // Setup phase: decode and latch the answer for the access phase
        if (psel && !penable && !r_ff.pready) begin
            nxt_r.pready = 1'b1;
            nxt_r.prdata = 32'h0000_0000;
            if (paddr == `MID_OFF_CTRL) begin
                nxt_r.prdata[`MID_CTRL_RUN] = r_ff.run;
            end else if (paddr == `MID_OFF_STAT) begin
                nxt_r.prdata[`MID_STAT_CLS +: 3] = cls;
                nxt_r.prdata[`MID_STAT_KILL] = r_ff.kill;
                nxt_r.prdata[`MID_STAT_STALL] = r_ff.stall;
                nxt_r.prdata[`MID_STAT_COST +: 2] = r_ff.last_cost;
                nxt_r.prdata[`MID_STAT_Q +: 4] = r_ff.q;
            end else if (paddr == `MID_OFF_WREG) begin
                nxt_r.prdata[7:0] = r_ff.w;
            end else if (paddr == `MID_OFF_INSTR) begin
                nxt_r.prdata[13:0] = r_ff.ir;
            end else if (paddr == `MID_OFF_COUNT) begin
                nxt_r.prdata[15:0] = r_ff.retired;
            end else if (paddr == `MID_OFF_PTRSRC) begin
                nxt_r.prdata[1:0] = r_ff.ptr_prog;
            end else begin
                nxt_r.pslverr = 1'b1;
            end
        end
        // Access phase completes: writes take effect here only
        if (apb_wr) begin
            if (paddr == `MID_OFF_CTRL) begin
                nxt_r.run = pwdata[`MID_CTRL_RUN];
            end else if (paddr == `MID_OFF_WREG) begin
                nxt_r.w = pwdata[7:0];
            end else if (paddr == `MID_OFF_PTRSRC) begin
                nxt_r.ptr_prog = pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= ST_RST;
        end else if (clk_en) begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr;
    assign fetch_take = r_ff.fetch;
    assign flow_change = r_ff.flow;
    assign fr_addr = r_ff.fr_addr;
    assign fr_rd = r_ff.fr_rd;
    assign fr_wr = r_ff.fr_wr;
    assign fr_wdata = r_ff.fr_wdata;
    assign indirect_pointer_step = r_ff.step;
    assign indirect_pointer_sel = r_ff.step_sel;
    assign ptr_step_style = r_ff.step_style;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !clk_en || !r_ff.run);

    fetch_space_a: assert property (
        r_ff.fetch |=> !r_ff.fetch [*3]
    ) else $error("fetch pulses closer than four clocks");

    rmw_order_a: assert property (
        r_ff.fr_wr |-> $past(r_ff.fr_rd, 2) && $past(r_ff.fr_addr, 2) == r_ff.fr_addr
    ) else $error("file write without the read two clocks before");

    flush_nop_a: assert property (
        r_ff.flow |-> r_ff.kill && r_ff.ir == `MID_NOP
    ) else $error("flow change did not discard the fetched word");

    one_cycle_a: assert property (
        (r_ff.q == MID_Q1 && ex && !ind_hit && !flow_fix && skip == MID_SK_NONE)
        |-> ##4 (r_ff.q == MID_Q1 && !r_ff.kill && !r_ff.stall)
    ) else $error("plain instruction took more than one cycle");

    two_cycle_a: assert property (
        (r_ff.q == MID_Q1 && ex && flow_fix && !ind_hit)
        |-> ##4 r_ff.kill ##4 (!r_ff.kill && !r_ff.stall)
    ) else $error("flow instruction did not take two cycles");

    ind_extra_a: assert property (
        (r_ff.q == MID_Q1 && ex && ind_hit) |-> ##4 r_ff.stall [*4] ##1 !r_ff.stall
    ) else $error("program-memory indirect access missed its added cycle");

    dest_route_a: assert property (
        (r_ff.q == MID_Q3 && ex && cls == MID_CL_BYTE && uses_file)
        |=> r_ff.fr_wr == r_ff.ir[7]
    ) else $error("destination bit not honoured");

    addr_field_a: assert property (
        (r_ff.fr_rd && !ptr_step) |-> r_ff.fr_addr == r_ff.ir[6:0]
    ) else $error("file address differs from the operand");

    bit_pos_a: assert property (
        (r_ff.fr_wr && r_ff.ir[13:11] == 3'b010)
        |-> r_ff.fr_wdata[r_ff.ir[9:7]] == r_ff.ir[10]
    ) else $error("bit operation hit the wrong bit");

    step_sel_a: assert property (
        r_ff.step |-> r_ff.step_sel == r_ff.ir[2] && r_ff.step_style == r_ff.ir[1:0]
    ) else $error("pointer step select or style wrong");

    skip_taken_a: assert property (
        (r_ff.q == MID_Q4 && ex && !ind_hit && skip_hit)
        |=> r_ff.fetch && r_ff.flow && r_ff.kill
    ) else $error("taken skip did not discard the next word");

    skip_miss_a: assert property (
        (r_ff.q == MID_Q4 && ex && !ind_hit && !flow_fix && !skip_hit)
        |=> r_ff.fetch && !r_ff.kill
    ) else $error("untaken skip or plain instruction lost a cycle");

    read_always_a: assert property (
        (r_ff.q == MID_Q1 && ex && uses_file) |=> r_ff.fr_rd && r_ff.fr_addr == dec_addr
    ) else $error("file register not read before its write");

    kill_quiet_a: assert property (
        (r_ff.kill || r_ff.stall) |-> !r_ff.fr_rd && !r_ff.fr_wr && !r_ff.step
    ) else $error("discarded cycle touched a file register");

    step_phase_a: assert property (
        r_ff.step |-> r_ff.q == MID_Q4
    ) else $error("pointer step outside the last phase");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    flow_seen_c: cover property (r_ff.flow);
    ind_seen_c: cover property (r_ff.stall ##4 r_ff.flow);
    skip_seen_c: cover property (r_ff.q == MID_Q4 && ex && skip_hit && skip != MID_SK_NONE);
    step_seen_c: cover property (r_ff.step);
    bit_write_c: cover property (r_ff.fr_wr && r_ff.ir[13:11] == 3'b010);
endmodule : mid_core

// ### src/mid_map.svh
// Address map, field positions, reset values and cycle counts of the instruction sequencer
// Functional notes
// - Instruction words are 14 bits, opcode plus every operand.
// - Each opcode is sorted into byte, bit, or literal/control class.
// - Instructions outside the exceptions finish in exactly one instruction cycle.
// - Both subroutine calls take two instruction cycles.
// - Every return form takes two instruction cycles.
// - Jumps and taken skip or count-and-skip operations take two instruction cycles.
// - File address operand is 7 bits, 0x00 to 0x7F in the bank.
// - Bit operand selects one bit of the addressed 8-bit register.
// - Don't-care encoding bits never change decoding.
// - Destination bit clear sends result to W, set sends it to the file.
// - Pointer operand selects indirect pointer pair 0 or 1.
// - Pointer step instructions carry a two-bit pre/post increment/decrement style.
// - Indirect access through a program-memory pointer adds one instruction cycle.
// - One instruction cycle spans four oscillator clocks.
// - Every file-register instruction reads, modifies, then stores its result.
// - The read happens even when the instruction only writes the register.
`ifndef MID_MAP_SVH
`define MID_MAP_SVH
`define MID_OFF_CTRL 12'h000
`define MID_OFF_STAT 12'h004
`define MID_OFF_WREG 12'h008
`define MID_OFF_INSTR 12'h00C
`define MID_OFF_COUNT 12'h010
`define MID_OFF_PTRSRC 12'h014
`define MID_CTRL_RUN 0
`define MID_STAT_CLS 0
`define MID_STAT_KILL 3
`define MID_STAT_STALL 4
`define MID_STAT_COST 5
`define MID_STAT_Q 8
`define MID_RST_RUN 1'h0
`define MID_RST_W 8'h00
`define MID_RST_PTRSRC 2'h0
`define MID_NOP 14'h0000
`define MID_COST_ONE 2'h1
`endif

// ### src/mid_pkg.sv
// Types shared by the instruction sequencer modules
package mid_pkg;
    // Four oscillator clocks make one instruction cycle
    typedef enum logic [3:0] {
        MID_Q1 = 4'b0001,
        MID_Q2 = 4'b0010,
        MID_Q3 = 4'b0100,
        MID_Q4 = 4'b1000
    } mid_q_t;
    typedef enum logic [2:0] {
        MID_CL_BYTE = 3'b001,
        MID_CL_BIT = 3'b010,
        MID_CL_LIT = 3'b100
    } mid_cls_t;
    typedef enum logic [1:0] {
        MID_STEP_PREINC = 2'b00,
        MID_STEP_PREDEC = 2'b01,
        MID_STEP_POSTINC = 2'b10,
        MID_STEP_POSTDEC = 2'b11
    } mid_step_t;
    typedef enum logic [3:0] {
        MID_SK_NONE = 4'b0001,
        MID_SK_BCLR = 4'b0010,
        MID_SK_BSET = 4'b0100,
        MID_SK_ZERO = 4'b1000
    } mid_skip_t;
endpackage : mid_pkg

// ### src/mid_dec.sv
// Instruction word decoder: class, operand fields, routing and flow kind
`timescale 1ns/1ps
module mid_dec (
    // Instruction word
    input wire logic [13:0] instr,
    // Decoded fields
    output mid_pkg::mid_cls_t cls,
    output logic [6:0] file_addr,
    output logic [2:0] bit_no,
    output logic dest_file,
    output logic dest_w,
    output logic uses_file,
    output logic ind_use,
    output logic ind_sel,
    output logic ptr_step,
    output mid_pkg::mid_step_t ptr_step_style,
    output logic flow_fix,
    output mid_pkg::mid_skip_t skip
);
    import mid_pkg::*;

    logic ctl_grp;
    logic shift_grp;

    always_comb begin
        // Operand fields come from fixed positions of the 14-bit word
        ctl_grp = instr[13:7] == 7'h00;
        ptr_step = instr[13:5] == 9'h000 && instr[4];
        shift_grp = instr[13:12] == 2'b11 && (instr[11:8] == 4'h5 || instr[11:8] == 4'h6
            || instr[11:8] == 4'h7 || instr[11:8] == 4'hB || instr[11:8] == 4'hD);
        // Class sort
        if (instr[13:12] == 2'b00 && !ctl_grp) begin
            cls = MID_CL_BYTE;
        end else if (instr[13:12] == 2'b01) begin
            cls = MID_CL_BIT;
        end else if (shift_grp) begin
            cls = MID_CL_BYTE;
        end else begin
            cls = MID_CL_LIT;
        end
        // Seven-bit address, or the pointer's access register
        file_addr = ptr_step ? {6'h00, instr[2]} : instr[6:0];
        bit_no = instr[9:7];
        ptr_step_style = mid_step_t'(instr[1:0]);
        // Clear-W ignores its low bits; only the destination bit sets it apart
        uses_file = (cls == MID_CL_BYTE && !(instr[13:8] == 6'h01 && !instr[7]))
            || cls == MID_CL_BIT || ptr_step;
        ind_use = uses_file && file_addr[6:1] == 6'h00;
        ind_sel = file_addr[0];
        // Destination select for byte, bit, literal and pointer-step operations
        if (cls == MID_CL_BIT) begin
            dest_file = !instr[11];
        end else if (ptr_step) begin
            dest_file = instr[3];
        end else begin
            dest_file = cls == MID_CL_BYTE && instr[7];
        end
        dest_w = (cls == MID_CL_BYTE && !instr[7]) || instr[13:8] == 6'h30
            || instr[13:8] == 6'h34 || (ptr_step && !instr[3]);
        // Calls, returns and jumps
        flow_fix = instr[13:12] == 2'b10 || (instr[13:4] == 10'h000 && instr[3])
            || instr[13:8] == 6'h34 || instr[13:9] == 5'b11001;
        if (cls == MID_CL_BIT && instr[11:10] == 2'b10) begin
            skip = MID_SK_BCLR;
        end else if (cls == MID_CL_BIT && instr[11:10] == 2'b11) begin
            skip = MID_SK_BSET;
        end else if (instr[13:8] == 6'h0B || instr[13:8] == 6'h0F) begin
            skip = MID_SK_ZERO;
        end else begin
            skip = MID_SK_NONE;
        end
    end
endmodule : mid_dec

// ### src/mid_alu.sv
// Modify step of read-modify-write and skip condition
`timescale 1ns/1ps
module mid_alu (
    // Operands
    input wire logic [13:0] instr,
    input wire logic [2:0] bit_no,
    input wire mid_pkg::mid_skip_t skip,
    input wire logic [7:0] fval,
    input wire logic [7:0] wval,
    // Result
    output logic [7:0] res,
    output logic skip_hit
);
    import mid_pkg::*;

    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction : bit_mask

    always_comb begin
        res = fval;
        case (instr[13:8])
            6'h00: res = (instr[7:3] == 5'b00010) ? fval : wval;
            6'h01: res = 8'h00;
            6'h02: res = fval - wval;
            6'h03, 6'h0B: res = fval - 8'h01;
            6'h04: res = wval | fval;
            6'h05: res = wval & fval;
            6'h06: res = wval ^ fval;
            6'h07: res = wval + fval;
            6'h09: res = ~fval;
            6'h0A, 6'h0F: res = fval + 8'h01;
            6'h30, 6'h34: res = instr[7:0];
            6'h35: res = {fval[6:0], 1'b0};
            6'h36: res = {1'b0, fval[7:1]};
            6'h37: res = {fval[7], fval[7:1]};
            default: begin
                // One bit of the eight is changed
                if (instr[13:10] == 4'b0100) begin
                    res = fval & ~bit_mask(bit_no);
                end else if (instr[13:10] == 4'b0101) begin
                    res = fval | bit_mask(bit_no);
                end
            end
        endcase
        case (skip)
            MID_SK_BCLR: skip_hit = (fval & bit_mask(bit_no)) == 8'h00;
            MID_SK_BSET: skip_hit = (fval & bit_mask(bit_no)) != 8'h00;
            MID_SK_ZERO: skip_hit = res == 8'h00;
            default: skip_hit = 1'b0;
        endcase
    end
endmodule : mid_alu

// ### tb/mid_pm.sv
// Program memory model feeding instruction words
`timescale 1ns/1ps
module mid_pm (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fetch side
    input wire logic fetch_take,
    output logic [13:0] instr_word,
    output logic instr_valid
);
    logic [13:0] mem [0:15];
    int len;
    int pc_ff;
    logic tog_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_ff <= 0;
            tog_ff <= 1'b0;
        end else begin
            tog_ff <= ~tog_ff;
            if (fetch_take) begin
                pc_ff <= pc_ff + 1;
            end
        end
    end
    // Past the end the bus toggles so no stale word is seen
    assign instr_valid = pc_ff < len;
    assign instr_word = instr_valid ? mem[pc_ff] : {7{tog_ff, ~tog_ff}};
endmodule : mid_pm

// ### tb/testbench.sv
// Self-checking bench of the instruction sequencer
`timescale 1ns/1ps
`include "mid_map.svh"
module testbench;
    import mid_pkg::*;
    // ----------------------------------------
    // Program and expectations
    // ----------------------------------------
    // Flow opcodes are plain defaults
    localparam logic [13:0] OP_JUMP = 14'h2800;
    localparam logic [13:0] OP_EXIT = 14'h0008;
    localparam logic [13:0] PROG [0:15] = '{14'h07A0, 14'h0103, 14'h0721, 14'h01A2,
        OP_JUMP, 14'h0AA3, 14'h09A4, 14'h0A80, 14'h0A81, OP_EXIT, 14'h0AA3,
        14'h15A5, 14'h19A5, 14'h1DA5, 14'h0AA3, 14'h001E};
    localparam int GAP [0:15] = '{4, 4, 4, 4, 4, 4, 4, 8, 4, 4, 4, 4, 4, 4, 4, 4};
    localparam logic [6:0] RDA [0:9] = '{7'h20, 7'h21, 7'h22, 7'h24, 7'h00, 7'h01,
        7'h25, 7'h25, 7'h25, 7'h01};
    localparam logic [14:0] WRX [0:6] = '{{7'h20, 8'h15}, {7'h22, 8'h00},
        {7'h24, 8'hA5}, {7'h00, 8'h80}, {7'h01, 8'h00}, {7'h25, 8'h2D}, {7'h01, 8'h03}};
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, instr_valid, fetch_take, flow_change, fr_rd, fr_wr;
    logic ptr_step, ptr_sel;
    logic [1:0] ptr_style;
    logic [13:0] instr_word;
    logic [6:0] fr_addr;
    logic [7:0] fr_rdata, fr_wdata;
    logic [7:0] fmem [0:127];
    int cyc = 0;
    int rd_cyc = 0;
    int num_errors = 0;
    int samples_checked = 0;
    int ft_q[$];
    int fc_q[$];
    logic [6:0] rd_q[$];
    logic [14:0] wr_q[$];
    logic [2:0] st_q[$];
    always #5 pclk = ~pclk;
    assign fr_rdata = fmem[fr_addr];
    mid_core u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_word(instr_word), .instr_valid(instr_valid), .fetch_take(fetch_take),
        .flow_change(flow_change), .fr_addr(fr_addr), .fr_rd(fr_rd), .fr_rdata(fr_rdata),
        .fr_wr(fr_wr), .fr_wdata(fr_wdata), .indirect_pointer_step(ptr_step),
        .indirect_pointer_sel(ptr_sel), .ptr_step_style(ptr_style));
    mid_pm u_pm (.pclk(pclk), .presetn(presetn), .fetch_take(fetch_take),
        .instr_word(instr_word), .instr_valid(instr_valid));
    // ----------------------------------------
    // Monitor and file register model
    // ----------------------------------------
    always @(posedge pclk) cyc <= cyc + 1;
    always @(negedge pclk) begin
        if (fetch_take) ft_q.push_back(cyc);
        if (flow_change) fc_q.push_back(ft_q.size() - 1);
        if (ptr_step) st_q.push_back({ptr_sel, ptr_style});
        if (fr_rd) begin
            rd_q.push_back(fr_addr);
            rd_cyc = cyc;
        end
        if (fr_wr) begin
            wr_q.push_back({fr_addr, fr_wdata});
            fmem[fr_addr] = fr_wdata;
            check(32'(cyc - rd_cyc), 32'h2);
            check(32'(fr_addr), 32'(rd_q[$]));
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 128; i++) fmem[i] = 8'(i);
        fmem[7'h20] = 8'h10;
        fmem[7'h21] = 8'h03;
        fmem[7'h23] = 8'h3C;
        fmem[7'h24] = 8'h5A;
        fmem[7'h00] = 8'h7F;
        fmem[7'h01] = 8'hFF;
        u_pm.len = 16;
        for (int i = 0; i < 16; i++) u_pm.mem[i] = PROG[i];
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MID_OFF_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `MID_OFF_WREG, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `MID_OFF_STAT, 32'h0);
        check(rd & 32'h0F00, 32'h0100);
        apb(1'b0, 12'h018, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("Reset and map test done");
        apb(1'b1, `MID_OFF_WREG, 32'h5);
        apb(1'b1, `MID_OFF_PTRSRC, 32'h1);
        apb(1'b1, `MID_OFF_CTRL, 32'h1);
        for (int n = 0; n < 300 && ft_q.size() < 17; n++) @(posedge pclk);
        if (ft_q.size() < 17) begin
            num_errors++;
            conclude();
        end
        repeat (8) @(posedge pclk);
        apb(1'b1, `MID_OFF_CTRL, 32'h0);
        apb(1'b0, `MID_OFF_WREG, 32'h0);
        check(rd, 32'h3);
        for (int i = 0; i < 16; i++) check(32'(ft_q[i + 1] - ft_q[i]), GAP[i]);
        check(32'(fc_q.size()), 32'h3);
        check(32'(fc_q[0]), 32'h5);
        check(32'(fc_q[1]), 32'hA);
        check(32'(fc_q[2]), 32'hE);
        check(32'(rd_q.size()), 32'hA);
        for (int i = 0; i < 10; i++) check(32'(rd_q[i]), 32'(RDA[i]));
        check(32'(wr_q.size()), 32'h7);
        for (int i = 0; i < 7; i++) check(32'(wr_q[i]), 32'(WRX[i]));
        check(32'(st_q.size()), 32'h1);
        check(32'(st_q[0]), 32'h6);
        check(32'(fmem[7'h23]), 32'h3C);
        $display("Program run test done");
        conclude();
    end
endmodule : testbench
